// >>> core/amsp_adc_port.sv
`timescale 1ns/100ps
module amsp_adc_port (
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic i_sclk,
	input wire logic i_cs_n,
	input wire logic i_din,
	input wire logic i_analog_channel_hi,
	input wire logic i_cmp_hi,
	output logic o_dout,
	output logic o_dout_oe,
	output logic o_eoc_n,
	output logic o_convert_start_en,
	output logic o_ref_neg_sel,
	output logic [1:0] o_clock_mode,
	output logic o_hold,
	output logic [amsp_pkg::RES_W-1:0] o_dac,
	output logic [amsp_pkg::CH_W-1:0] o_mux_ch,
	output logic o_diff,
	output logic o_bipolar,
	output logic o_temp_sel
);
	// synchronisers: sclk, cs_n, din, start pin, comparator
	logic [4:0] sync1_r;
	logic [4:0] sync2_r;
	logic sclk_d_r;
	logic cs_d_r;
	logic conv_start_d_r;
	logic sclk_s;
	logic cs_s;
	logic din_s;
	logic conv_start_s;
	logic cmp_s;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_fall;
	logic conv_start_fall;

	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			sync1_r <= 5'h1f;
			sync2_r <= 5'h1f;
			sclk_d_r <= 1'b1;
			cs_d_r <= 1'b1;
			conv_start_d_r <= 1'b1;
		end
		else
		begin
			sync1_r <= {i_sclk, i_cs_n, i_din, i_analog_channel_hi, i_cmp_hi};
			sync2_r <= sync1_r;
			sclk_d_r <= sclk_s;
			cs_d_r <= cs_s;
			conv_start_d_r <= conv_start_s;
		end
	end

	assign {sclk_s, cs_s, din_s, conv_start_s, cmp_s} = sync2_r;
	assign sclk_rise = !cs_s && sclk_s && !sclk_d_r;
	assign sclk_fall = !cs_s && !sclk_s && sclk_d_r;
	assign cs_fall = !cs_s && cs_d_r;

	// configuration
	logic [1:0] clock_mode_r;
	logic ref_neg_r;
	logic [1:0] follow_r;
	logic [amsp_pkg::PAIR_N-1:0] uni_r;
	logic [amsp_pkg::PAIR_N-1:0] bip_r;
	logic [amsp_pkg::CH_W-1:0] chan_r;
	logic temp_req_r;
	logic conv_start_en_r;

	assign conv_start_fall = conv_start_en_r && !conv_start_s && conv_start_d_r;

	// command byte receiver
	logic [amsp_pkg::BYTE_W-1:0] rx_sh_r;
	logic [2:0] rx_cnt_r;
	logic first_byte_r;
	logic rx_done;
	logic [amsp_pkg::BYTE_W-1:0] rx_byte;
	logic conv_cmd;

	assign rx_done = sclk_rise && rx_cnt_r == amsp_pkg::RX_LAST;
	assign rx_byte = {rx_sh_r[amsp_pkg::BYTE_W-2:0], din_s};
	assign conv_cmd = rx_done && first_byte_r && rx_byte[amsp_pkg::CMD_CONV_BIT];

	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			rx_sh_r <= '0;
			rx_cnt_r <= '0;
			first_byte_r <= 1'b1;
		end
		else if (cs_fall)
		begin
			rx_cnt_r <= '0;
			first_byte_r <= 1'b1;
		end
		else if (sclk_rise)
		begin
			rx_sh_r <= rx_byte;
			rx_cnt_r <= rx_cnt_r + 1'b1;
			if (rx_done)
				first_byte_r <= 1'b0;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			clock_mode_r <= amsp_pkg::CM_RESET;
			ref_neg_r <= 1'b0;
			follow_r <= amsp_pkg::FOLLOW_NONE;
			uni_r <= '0;
			bip_r <= '0;
			chan_r <= '0;
			temp_req_r <= 1'b0;
			conv_start_en_r <= 1'b0;
		end
		else if (rx_done && first_byte_r)
		begin
			follow_r <= amsp_pkg::FOLLOW_NONE;
			if (conv_cmd)
			begin
				chan_r <= rx_byte[amsp_pkg::CHAN_HI:amsp_pkg::CHAN_LO];
				temp_req_r <= rx_byte[amsp_pkg::TEMP_BIT];
			end
			else if (rx_byte[amsp_pkg::CMD_TAG_HI:amsp_pkg::CMD_TAG_LO] == amsp_pkg::SETUP_TAG)
			begin
				clock_mode_r <= rx_byte[amsp_pkg::CM_HI:amsp_pkg::CM_LO];
				conv_start_en_r <= !rx_byte[amsp_pkg::CM_HI];
				ref_neg_r <= rx_byte[amsp_pkg::REFSEL_BIT];
				follow_r <= rx_byte[amsp_pkg::FOLLOW_HI:amsp_pkg::FOLLOW_LO];
			end
		end
		else if (rx_done)
		begin
			follow_r <= amsp_pkg::FOLLOW_NONE;
			if (follow_r == amsp_pkg::FOLLOW_UNI)
			begin
				uni_r <= rx_byte;
				bip_r <= bip_r & ~rx_byte;
			end
			else if (follow_r == amsp_pkg::FOLLOW_BIP)
			begin
				bip_r <= rx_byte;
				uni_r <= uni_r & ~rx_byte;
			end
		end
	end

	// conversion engine
	amsp_fifo_if #(.WIDTH(amsp_pkg::ENTRY_W)) fq ();
	amsp_pkg::amsp_sar_e st_r;
	logic [amsp_pkg::TMR_W-1:0] tmr_r;
	logic [3:0] bit_idx_r;
	logic [amsp_pkg::RES_W-1:0] dac_r;
	logic hold_r;
	logic [amsp_pkg::CH_W-1:0] mux_ch_r;
	logic diff_r;
	logic bipolar_r;
	logic temp_sel_r;
	logic start;
	logic conv_done;
	logic pair_diff;
	logic [2:0] pair;

	assign start = (conv_cmd && clock_mode_r[1]) || conv_start_fall;
	assign conv_done = st_r == amsp_pkg::SAR_PUSH && fq.wr_ready;
	assign pair = rx_byte[amsp_pkg::CHAN_HI:amsp_pkg::CHAN_LO+1];
	assign pair_diff = uni_r[pair] || bip_r[pair];
	assign fq.wr_valid = st_r == amsp_pkg::SAR_PUSH;
	assign fq.wr_data = {dac_r[amsp_pkg::RES_W-1] ^ bipolar_r, dac_r[amsp_pkg::RES_W-2:0],
		{amsp_pkg::SUB_W{1'b0}}};

	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			st_r <= amsp_pkg::SAR_IDLE;
			tmr_r <= '0;
			bit_idx_r <= '0;
			dac_r <= '0;
			hold_r <= 1'b0;
		end
		else
		begin
			unique case (st_r)
				amsp_pkg::SAR_IDLE:
				begin
					tmr_r <= '0;
					if (start)
						st_r <= amsp_pkg::SAR_TRACK;
				end
				amsp_pkg::SAR_TRACK:
				begin
					tmr_r <= tmr_r + 1'b1;
					if (tmr_r == amsp_pkg::ACQ_LAST)
					begin
						st_r <= amsp_pkg::SAR_TEST;
						tmr_r <= '0;
						hold_r <= 1'b1;
						bit_idx_r <= amsp_pkg::BIT_MSB;
						dac_r <= amsp_pkg::DAC_MID;
					end
				end
				amsp_pkg::SAR_TEST:
				begin
					tmr_r <= tmr_r + 1'b1;
					if (tmr_r == amsp_pkg::BIT_LAST)
					begin
						tmr_r <= '0;
						dac_r[bit_idx_r] <= cmp_s;
						if (bit_idx_r == '0)
							st_r <= amsp_pkg::SAR_PUSH;
						else
						begin
							dac_r[bit_idx_r - 4'h1] <= 1'b1;
							bit_idx_r <= bit_idx_r - 4'h1;
						end
					end
				end
				amsp_pkg::SAR_PUSH:
				begin
					if (fq.wr_ready)
					begin
						st_r <= amsp_pkg::SAR_IDLE;
						hold_r <= 1'b0;
					end
				end
			endcase
		end
	end

	// channel routing latched at the requesting byte
	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			mux_ch_r <= '0;
			diff_r <= 1'b0;
			bipolar_r <= 1'b0;
			temp_sel_r <= 1'b0;
		end
		else if (conv_cmd)
		begin
			diff_r <= pair_diff;
			mux_ch_r <= pair_diff ? {pair, 1'b0} : rx_byte[amsp_pkg::CHAN_HI:amsp_pkg::CHAN_LO];
			bipolar_r <= pair_diff && bip_r[pair];
			temp_sel_r <= rx_byte[amsp_pkg::TEMP_BIT];
		end
	end

	amsp_fifo #(.WIDTH(amsp_pkg::ENTRY_W), .DEPTH(amsp_pkg::FIFO_DEPTH)) u_fifo (
		.i_mclk(i_mclk),
		.i_rstn(i_rstn),
		.q(fq.store)
	);

	// end of conversion
	logic eoc_n_r;
	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
			eoc_n_r <= 1'b1;
		else if (clock_mode_r == amsp_pkg::CM_SERIAL_EXT || cs_fall || conv_start_fall)
			eoc_n_r <= 1'b1;
		else if (conv_done)
			eoc_n_r <= 1'b0;
	end

	// result shifter
	logic [amsp_pkg::WORD_W-1:0] tx_sh_r;
	logic [3:0] tx_cnt_r;
	logic oe_r;
	logic tx_load;
	logic held_r;

	assign tx_load = cs_fall || (sclk_fall && tx_cnt_r == amsp_pkg::TX_LAST);
	// pop only once the first bit is out, so a frame cut after a reload keeps the word
	assign fq.rd_ready = held_r && sclk_fall && !tx_load && tx_cnt_r == '0;

	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			tx_sh_r <= '0;
			tx_cnt_r <= '0;
			oe_r <= 1'b0;
			held_r <= 1'b0;
		end
		else
		begin
			oe_r <= !cs_s;
			if (tx_load)
			begin
				tx_sh_r <= amsp_pkg::amsp_fmt_word(fq.rd_valid, fq.rd_data);
				tx_cnt_r <= '0;
				held_r <= fq.rd_valid;
			end
			else if (sclk_fall)
			begin
				tx_sh_r <= {tx_sh_r[amsp_pkg::WORD_W-2:0], 1'b0};
				tx_cnt_r <= tx_cnt_r + 1'b1;
				held_r <= 1'b0;
			end
		end
	end

	assign o_dout = tx_sh_r[amsp_pkg::WORD_W-1];
	assign o_dout_oe = oe_r;
	assign o_eoc_n = eoc_n_r;
	assign o_convert_start_en = conv_start_en_r;
	assign o_ref_neg_sel = ref_neg_r;
	assign o_clock_mode = clock_mode_r;
	assign o_hold = hold_r;
	assign o_dac = dac_r;
	assign o_mux_ch = mux_ch_r;
	assign o_diff = diff_r;
	assign o_bipolar = bipolar_r;
	assign o_temp_sel = temp_sel_r;

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rstn);

	sequence s_hold_taken;
		$rose(hold_r);
	endsequence
	sequence s_bits_done;
		##50 st_r == amsp_pkg::SAR_PUSH;
	endsequence

	a_idle_no_shift: assert property (cs_s |=> $stable(rx_sh_r))
		else $error("input shifted while deselected");
	a_dout_hiz_off: assert property (cs_s |=> !o_dout_oe)
		else $error("data output driven while deselected");
	a_din_on_rise: assert property (sclk_rise |=> rx_sh_r[0] == $past(din_s))
		else $error("input bit not taken on rising edge");
	a_dout_on_fall: assert property (!sclk_fall && !cs_fall |=> $stable(o_dout))
		else $error("output bit moved without falling edge");
	a_eoc_low_done: assert property (conv_done && !cs_fall && !conv_start_fall
		&& clock_mode_r != amsp_pkg::CM_SERIAL_EXT |=> !o_eoc_n)
		else $error("end of conversion not low after result");
	a_eoc_high_sel: assert property (cs_fall || conv_start_fall |=> o_eoc_n)
		else $error("end of conversion not high on start");
	a_pin_analog_quiet: assert property (!conv_start_en_r && st_r == amsp_pkg::SAR_IDLE
		&& !conv_cmd |=> st_r == amsp_pkg::SAR_IDLE)
		else $error("analog pin started a conversion");
	a_sar_ten_bits: assert property (s_hold_taken |-> s_bits_done)
		else $error("successive approximation length wrong");
	a_se_unipolar: assert property (!o_diff |-> !o_bipolar)
		else $error("single-ended channel in bipolar range");
	a_empty_reads_zero: assert property (tx_load && !fq.rd_valid |=> tx_sh_r == '0)
		else $error("empty buffer read nonzero");
	a_lead_zeros: assert property (tx_load |=> tx_sh_r[amsp_pkg::WORD_W-1 -: amsp_pkg::LEAD_W] == '0)
		else $error("result word lacks leading zeros");
	a_mode_from_setup: assert property (rx_done && first_byte_r && !rx_byte[amsp_pkg::CMD_CONV_BIT]
		&& rx_byte[amsp_pkg::CMD_TAG_HI:amsp_pkg::CMD_TAG_LO] == amsp_pkg::SETUP_TAG
		|=> o_clock_mode == $past(rx_byte[amsp_pkg::CM_HI:amsp_pkg::CM_LO]))
		else $error("clock mode not taken from setup byte");
endmodule : amsp_adc_port

// >>> core/amsp_fifo.sv
`timescale 1ns/100ps
module amsp_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 8
) (
	input wire logic i_mclk,
	input wire logic i_rstn,
	amsp_fifo_if.store q
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr_r;
	logic [AW:0] rd_ptr_r;
	logic full;
	logic empty;
	logic push;
	logic pop;

	assign empty = wr_ptr_r == rd_ptr_r;
	assign full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
	assign q.wr_ready = !full;
	assign q.rd_valid = !empty;
	assign q.rd_data = mem[rd_ptr_r[AW-1:0]];
	assign push = q.wr_valid && !full;
	assign pop = q.rd_ready && !empty;

	always_ff @(posedge i_mclk)
	begin
		if (push)
			mem[wr_ptr_r[AW-1:0]] <= q.wr_data;
	end

	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_r <= wr_ptr_r + 1'b1;
			if (pop)
				rd_ptr_r <= rd_ptr_r + 1'b1;
		end
	end

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rstn);
	a_fifo_no_overfill: assert property (full && !pop |=> full && $stable(wr_ptr_r))
		else $error("fifo pointer moved while full");
endmodule : amsp_fifo

// >>> core/amsp_fifo_if.sv
`timescale 1ns/100ps
interface amsp_fifo_if #(parameter int WIDTH = 12);
	logic wr_valid;
	logic wr_ready;
	logic [WIDTH-1:0] wr_data;
	logic rd_valid;
	logic rd_ready;
	logic [WIDTH-1:0] rd_data;
	modport prod (output wr_valid, output wr_data, input wr_ready,
		input rd_valid, input rd_data, output rd_ready);
	modport store (input wr_valid, input wr_data, output wr_ready,
		output rd_valid, output rd_data, input rd_ready);
endinterface : amsp_fifo_if

// >>> core/amsp_pkg.sv
package amsp_pkg;
	localparam int BYTE_W = 8;
	localparam int RES_W = 10;
	localparam int SUB_W = 2;
	localparam int LEAD_W = 4;
	localparam int WORD_W = 16;
	localparam int ENTRY_W = RES_W + SUB_W;
	localparam int FIFO_DEPTH = 8;
	localparam int CH_W = 4;
	localparam int PAIR_N = 8;
	// command byte layout
	localparam int CMD_CONV_BIT = 7;
	localparam int CMD_TAG_HI = 7;
	localparam int CMD_TAG_LO = 6;
	localparam logic [1:0] SETUP_TAG = 2'h1;
	localparam int CHAN_HI = 6;
	localparam int CHAN_LO = 3;
	localparam int TEMP_BIT = 0;
	localparam int CM_HI = 5;
	localparam int CM_LO = 4;
	localparam int REFSEL_BIT = 3;
	localparam int FOLLOW_HI = 1;
	localparam int FOLLOW_LO = 0;
	localparam logic [1:0] FOLLOW_NONE = 2'h0;
	localparam logic [1:0] FOLLOW_UNI = 2'h2;
	localparam logic [1:0] FOLLOW_BIP = 2'h3;
	// clock modes
	localparam logic [1:0] CM_START_INT = 2'h0;
	localparam logic [1:0] CM_START_EXT = 2'h1;
	localparam logic [1:0] CM_SERIAL_INT = 2'h2;
	localparam logic [1:0] CM_SERIAL_EXT = 2'h3;
	localparam logic [1:0] CM_RESET = CM_SERIAL_INT;
	// timing
	localparam int MCLK_PERIOD_NS = 8;
	localparam int T_ACQ_NS = 1400;
	localparam int T_BIT_NS = 40;
	localparam int ACQ_CYC = (T_ACQ_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
	localparam int BIT_CYC = (T_BIT_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
	localparam int TMR_W = 8;
	localparam logic [TMR_W-1:0] ACQ_LAST = TMR_W'(ACQ_CYC - 1);
	localparam logic [TMR_W-1:0] BIT_LAST = TMR_W'(BIT_CYC - 1);
	localparam logic [3:0] BIT_MSB = 4'(RES_W - 1);
	localparam logic [2:0] RX_LAST = 3'h7;
	localparam logic [3:0] TX_LAST = 4'hf;
	localparam logic [RES_W-1:0] DAC_MID = {1'b1, {(RES_W-1){1'b0}}};

	typedef enum logic [1:0] {SAR_IDLE, SAR_TRACK, SAR_TEST, SAR_PUSH} amsp_sar_e;

	function automatic logic [WORD_W-1:0] amsp_fmt_word(input logic vld,
		input logic [ENTRY_W-1:0] ent);
		amsp_fmt_word = vld ? {{LEAD_W{1'b0}}, ent} : '0;
	endfunction : amsp_fmt_word
endpackage : amsp_pkg

// >>> test/amsp_adc_port_tb.sv
`timescale 1ns/100ps
module amsp_adc_port_tb;
	logic i_mclk;
	logic i_rstn;
	logic sclk, cs_n, din, ach_hi, cmp_hi;
	logic dout, dout_oe, eoc_n, start_en, ref_neg_sel, hold, diff, bipolar, temp_sel;
	logic [1:0] clock_mode;
	logic [amsp_pkg::RES_W-1:0] dac;
	logic [amsp_pkg::CH_W-1:0] mux_ch;
	logic [amsp_pkg::RES_W-1:0] vin;
	logic [15:0] rx;
	int errors;
	int n_checks;

	// comparator: input at or above the trial code
	assign cmp_hi = (dac <= vin);

	amsp_adc_port u_dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_sclk(sclk), .i_cs_n(cs_n),
		.i_din(din), .i_analog_channel_hi(ach_hi), .i_cmp_hi(cmp_hi), .o_dout(dout),
		.o_dout_oe(dout_oe), .o_eoc_n(eoc_n), .o_convert_start_en(start_en),
		.o_ref_neg_sel(ref_neg_sel), .o_clock_mode(clock_mode), .o_hold(hold),
		.o_dac(dac), .o_mux_ch(mux_ch), .o_diff(diff), .o_bipolar(bipolar),
		.o_temp_sel(temp_sel));

	amsp_host_model u_host (.i_mclk(i_mclk), .i_dout(dout), .i_dout_oe(dout_oe),
		.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din));

	initial
	begin
		i_mclk = 1'b0;
		forever #4 i_mclk = ~i_mclk;
	end

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : report_and_stop

	task automatic wait_eoc();
		int k;
		logic seen;
		k = 0;
		seen = 1'b0;
		while (eoc_n !== 1'b0 && k < 600)
		begin
			@(posedge i_mclk);
			#1;
			k++;
			if (hold === 1'b1)
				seen = 1'b1;
		end
		check("eoc_n low", 16'(eoc_n), 16'h0);
		check("hold seen", 16'(seen), 16'h1);
		check("hold released", 16'(hold), 16'h0);
	endtask : wait_eoc

	task automatic pulse();
		@(posedge i_mclk);
		#1;
		ach_hi = 1'b0;
		repeat (8) @(posedge i_mclk);
		#1;
		ach_hi = 1'b1;
	endtask : pulse

	task automatic read_word(input logic [9:0] v, input logic bp);
		logic [9:0] r;
		r = bp ? {~v[9], v[8:0]} : v;
		u_host.frame(1'b1, 16'h0000, rx);
		check("word", rx, {4'h0, r, 2'h0});
		check("eoc_n after cs", 16'(eoc_n), 16'h1);
	endtask : read_word

	task automatic conv(input logic [3:0] ch, input logic [9:0] v, input logic dff,
		input logic bp, input logic tmp);
		vin = v;
		u_host.frame(1'b1, {1'b1, ch, 2'h0, tmp, 8'h00}, rx);
		check("temp_sel", 16'(temp_sel), 16'(tmp));
		check("mux_ch", 16'(mux_ch), 16'(ch));
		check("diff", 16'(diff), 16'(dff));
		check("bipolar", 16'(bipolar), 16'(bp));
		wait_eoc();
		check("dac", 16'(dac), 16'(v));
		read_word(v, bp);
		$display("conversion test on channel %0d done", ch);
	endtask : conv

	initial
	begin
		#300000;
		errors++;
		report_and_stop();
	end

	initial
	begin
		errors = 0;
		n_checks = 0;
		i_rstn = 1'b0;
		ach_hi = 1'b1;
		vin = 10'h000;
		repeat (20) @(posedge i_mclk);
		#1;
		i_rstn = 1'b1;
		repeat (4) @(posedge i_mclk);
		#1;
		check("oe reset", 16'(dout_oe), 16'h0);
		check("eoc reset", 16'(eoc_n), 16'h1);
		check("mode reset", 16'(clock_mode), 16'h2);
		check("start_en reset", 16'(start_en), 16'h0);
		$display("reset test done");
		u_host.frame(1'b1, 16'h0000, rx);
		check("empty word", rx, 16'h0000);
		check("oe in frame", 16'(u_host.oe_mid), 16'h1);
		check("oe after frame", 16'(dout_oe), 16'h0);
		u_host.frame(1'b0, 16'ha800, rx);
		repeat (300) @(posedge i_mclk);
		#1;
		check("no start with cs high", 16'(eoc_n), 16'h1);
		$display("chip-select test done");
		conv(4'h5, 10'h2a5, 1'b0, 1'b0, 1'b0);
		u_host.frame(1'b1, 16'h6b02, rx);
		check("ref sel", 16'(ref_neg_sel), 16'h1);
		conv(4'h2, 10'h123, 1'b1, 1'b1, 1'b0);
		u_host.frame(1'b1, 16'h6204, rx);
		check("ref off", 16'(ref_neg_sel), 16'h0);
		conv(4'h4, 10'h3ff, 1'b1, 1'b0, 1'b1);
		for (int m = 3; m >= 0; m--)
		begin
			u_host.frame(1'b1, {8'(8'h40 | (m << 4)), 8'h00}, rx);
			check("clock mode", 16'(clock_mode), 16'(m));
			check("start_en", 16'(start_en), 16'(m < 2));
		end
		vin = 10'h155;
		pulse();
		wait_eoc();
		vin = 10'h0aa;
		pulse();
		check("eoc on start pin", 16'(eoc_n), 16'h1);
		wait_eoc();
		read_word(10'h155, 1'b0);
		read_word(10'h0aa, 1'b0);
		$display("start pin test done");
		u_host.frame(1'b1, 16'h6000, rx);
		check("start_en off", 16'(start_en), 16'h0);
		pulse();
		repeat (300) @(posedge i_mclk);
		#1;
		check("pin ignored", 16'(eoc_n), 16'h1);
		read_word(10'h000, 1'b0);
		$display("analog pin test done");
		report_and_stop();
	end
endmodule : amsp_adc_port_tb

// >>> test/amsp_host_model.sv
`timescale 1ns/100ps
module amsp_host_model (
	input wire logic i_mclk,
	input wire logic i_dout,
	input wire logic i_dout_oe,
	output logic o_sclk,
	output logic o_cs_n,
	output logic o_din
);
	logic last_d;
	logic dout_w;
	logic oe_mid;

	initial
	begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		o_din = 1'b0;
		oe_mid = 1'b0;
		last_d = 1'b0;
	end

	always @(posedge i_mclk)
	begin
		if (i_dout_oe)
			last_d <= i_dout;
	end
	// released line shows the inverse of its last driven level
	assign dout_w = i_dout_oe ? i_dout : ~last_d;

	// sel low clocks the same pattern with chip-select left high
	task automatic frame(input logic sel, input logic [15:0] tx, output logic [15:0] rx);
		@(posedge i_mclk);
		#1;
		o_cs_n = ~sel;
		#64;
		oe_mid = i_dout_oe;
		for (int i = 15; i >= 0; i--)
		begin
			o_din = tx[i];
			#32;
			o_sclk = 1'b1;
			#32;
			// sampled late in the high phase, before the fall moves it
			rx[i] = dout_w;
			o_sclk = 1'b0;
		end
		#64;
		o_cs_n = 1'b1;
		o_din = ~o_din;
		#64;
	endtask : frame
endmodule : amsp_host_model
